// file: swc_pkg.sv
// shared constants and types of the channel configuration block
package swc_pkg;
	localparam int WORD_W = 16;
	localparam int DATA_W = 9;
	localparam int DUTY_W = 8;
	localparam int NUM_CH = 2;
	// serial word layout
	localparam int BIT_WD = 15;
	localparam int BIT_BANK = 13;
	localparam int ADDR_HI = 12;
	localparam int ADDR_LO = 10;
	localparam int SEL_HI = 2;
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_PWM = 3'h1;
	localparam logic [2:0] ADDR_LOAD_TYPE_INPUT = 3'h2;
	localparam logic [2:0] ADDR_OC = 3'h4;
	localparam logic [2:0] ADDR_GLOBAL = 3'h6;
	localparam logic [8:0] REG_RESET = 9'h000;
	localparam logic NORMAL_MODE = 1'h1;
	// pwm_duty_control fields
	localparam int PWM_ENABLE = 8;
	// channel_configuration fields
	localparam int LOAD_TYPE_INPUT_SHORT_OFF = 8;
	localparam int LOAD_TYPE_INPUT_ONOL_OFF = 7;
	localparam int LOAD_TYPE_INPUT_OFFOL_OFF = 6;
	localparam int LOAD_TYPE_INPUT_DIRECT_OFF = 5;
	localparam int LOAD_TYPE_INPUT_SLEW_HI = 4;
	localparam int LOAD_TYPE_INPUT_SLEW_LO = 3;
	localparam int LOAD_TYPE_INPUT_DELAY_HI = 2;
	// overcurrent_configuration fields
	localparam int OC_RANGE = 8;
	localparam int OC_PRESCALE = 7;
	localparam int OC_INTCLK = 6;
	localparam int OC_SENSE = 5;
	localparam int OC_WIN_FIRST = 4;
	localparam int OC_WIN_SECOND = 3;
	localparam int OC_UPPER = 2;
	localparam int OC_MIDDLE = 1;
	localparam int OC_LOWER = 0;
	// global_configuration start bits, indexed by channel
	localparam int GLB_START0 = 7;
	// lowest threshold levels
	localparam logic [1:0] LOW_THR_L1 = 2'h1;
	localparam logic [1:0] LOW_THR_L2 = 2'h2;
	localparam logic [1:0] LOW_THR_L3 = 2'h3;
	// pwm timing: 256 steps, delay unit in steps
	localparam int PRESCALE_SHORT = 256;
	localparam int PRESCALE_LONG = 512;
	localparam int DELAY_UNIT_LOG2 = 5;

	typedef enum logic {RX_IDLE, RX_SHIFT} swc_rx_state_type;

	typedef struct packed {
		logic		drive_on;
		logic		short_detect_en;
		logic		on_openload_en;
		logic		off_openload_en;
		logic [1:0]	slew_code;
		logic [1:0]	low_thr_level;
		logic		upper_thr_low;
		logic		middle_thr_used;
		logic		middle_thr_low;
		logic		thr_div_three;
		logic		sense_low_ratio;
		logic		sense_allowed;
		logic		motor_profile;
		logic [1:0]	window_code;
	} swc_ch_ctrl_type;
endpackage : swc_pkg

// file: swc_serial_port.sv
// 16-bit serial word receiver with reply shifter
`timescale 1ns/10ps
module swc_serial_port #(
	parameter int WORD_W = swc_pkg::WORD_W
) (
	input  wire logic			clk,
	input  wire logic			rst_n,
	input  wire logic			sclk,
	input  wire logic			csb_n,
	input  wire logic			mosi,
	input  wire logic [WORD_W-1:0]	reply_word,
	output logic			miso,
	output logic			word_strobe,
	output logic			word_reject,
	output logic [WORD_W-1:0]	word_data
);
	localparam int CNT_W = $clog2(WORD_W + 2);
	localparam logic [CNT_W-1:0] FULL = CNT_W'(WORD_W);

	swc_pkg::swc_rx_state_type	state_ff, nxt_state;
	logic				sclk_prev_ff, nxt_sclk_prev;
	logic [WORD_W-1:0]		shift_ff, nxt_shift;
	logic [WORD_W-1:0]		tx_ff, nxt_tx;
	logic [WORD_W-1:0]		data_ff, nxt_data;
	logic [CNT_W-1:0]		count_ff, nxt_count;
	logic				miso_ff, nxt_miso;
	logic				strobe_ff, nxt_strobe;
	logic				reject_ff, nxt_reject;
	logic				rise;
	logic				fall;

	assign rise = sclk & ~sclk_prev_ff;
	assign fall = ~sclk & sclk_prev_ff;

	// frame sequencing: sample on rising sclk, shift reply on falling
	always_comb
	begin
		nxt_state = state_ff;
		nxt_sclk_prev = sclk;
		nxt_shift = shift_ff;
		nxt_tx = tx_ff;
		nxt_data = data_ff;
		nxt_count = count_ff;
		nxt_miso = miso_ff;
		nxt_strobe = 1'b0;
		nxt_reject = 1'b0;
		case (state_ff)
			swc_pkg::RX_IDLE:
			begin
				nxt_miso = 1'b0;
				if (!csb_n)
				begin
					nxt_state = swc_pkg::RX_SHIFT;
					nxt_count = '0;
					nxt_tx = reply_word;
					nxt_miso = reply_word[WORD_W-1];
				end
			end
			swc_pkg::RX_SHIFT:
			begin
				if (csb_n)
				begin
					nxt_state = swc_pkg::RX_IDLE;
					// only an exact-length word with odd parity is taken
					if (count_ff == FULL && ^shift_ff)
					begin
						nxt_strobe = 1'b1;
						nxt_data = shift_ff;
					end
					else
						nxt_reject = 1'b1;
				end
				else
				begin
					if (rise)
					begin
						nxt_shift = {shift_ff[WORD_W-2:0], mosi};
						// saturate one past full so overlong frames stay bad
						if (count_ff <= FULL)
							nxt_count = count_ff + CNT_W'(1);
					end
					if (fall)
					begin
						nxt_tx = {tx_ff[WORD_W-2:0], 1'b0};
						nxt_miso = tx_ff[WORD_W-2];
					end
				end
			end
			default:
				nxt_state = swc_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_ff <= swc_pkg::RX_IDLE;
			sclk_prev_ff <= 1'b0;
			shift_ff <= '0;
			tx_ff <= '0;
			data_ff <= '0;
			count_ff <= '0;
			miso_ff <= 1'b0;
			strobe_ff <= 1'b0;
			reject_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			sclk_prev_ff <= nxt_sclk_prev;
			shift_ff <= nxt_shift;
			tx_ff <= nxt_tx;
			data_ff <= nxt_data;
			count_ff <= nxt_count;
			miso_ff <= nxt_miso;
			strobe_ff <= nxt_strobe;
			reject_ff <= nxt_reject;
		end
	end

	assign miso = miso_ff;
	assign word_strobe = strobe_ff;
	assign word_reject = reject_ff;
	assign word_data = data_ff;
endmodule : swc_serial_port

// file: swc_pwm_engine.sv
// per-channel pwm counter with prescaler and turn-on delay
`timescale 1ns/10ps
module swc_pwm_engine #(
	parameter int DUTY_W = swc_pkg::DUTY_W
) (
	input  wire logic			clk,
	input  wire logic			rst_n,
	input  wire logic			run,
	input  wire logic			enable,
	input  wire logic [DUTY_W-1:0]	duty,
	input  wire logic [2:0]		delay,
	input  wire logic			use_internal,
	input  wire logic			long_prescale,
	input  wire logic			int_tick,
	input  wire logic			ext_clk,
	output logic			pwm_on
);
	logic			ext_prev_ff, nxt_ext_prev;
	logic			half_ff, nxt_half;
	logic [DUTY_W-1:0]	phase_ff, nxt_phase;
	logic			on_ff, nxt_on;
	logic			ext_rise;
	logic			step;
	logic [DUTY_W-1:0]	offset;

	assign ext_rise = ext_clk & ~ext_prev_ff;
	// 256 steps per period: /256 takes every ext rise, /512 every second
	assign step = use_internal ? int_tick :
		(ext_rise & (~long_prescale | half_ff));
	// delay shifts the switch-on point by whole delay units
	assign offset = phase_ff - DUTY_W'({delay, {swc_pkg::DELAY_UNIT_LOG2{1'b0}}});

	// counter held at zero until started, so the start edge is a known instant
	always_comb
	begin
		nxt_ext_prev = ext_clk;
		nxt_half = half_ff;
		nxt_phase = phase_ff;
		if (!run)
		begin
			nxt_half = 1'b0;
			nxt_phase = '0;
		end
		else
		begin
			if (ext_rise)
				nxt_half = ~half_ff;
			if (step)
				nxt_phase = phase_ff + DUTY_W'(1);
		end
		// same compare for either clock source
		nxt_on = run & enable & (offset < duty);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ext_prev_ff <= 1'b0;
			half_ff <= 1'b0;
			phase_ff <= '0;
			on_ff <= 1'b0;
		end
		else
		begin
			ext_prev_ff <= nxt_ext_prev;
			half_ff <= nxt_half;
			phase_ff <= nxt_phase;
			on_ff <= nxt_on;
		end
	end

	assign pwm_on = on_ff;
endmodule : swc_pwm_engine

// file: swc_channel_config.sv
// dual-channel configuration register bank behind the serial port
// Notes on behaviour
// - pwm drives the channel only when pwm_duty_control bit 8 is set.
// - duty comes from pwm_duty_control bits 7:0, 256 levels.
// - duty applies with internal or external pwm clock alike.
// - controller sets start bit; pwm begins at that instant.
// - bank bit 13 routes writes to channel 0 or channel 1.
// - configuration bit 8 set disables short-to-supply detection.
// - configuration bit 7 set disables on-state open-load detection.
// - configuration bit 6 set disables off-state open-load detection.
// - bit 5 clear lets direct input drive; set means pwm only.
// - bits 4:3 pick slew rate, same for both edges.
// - bits 2:0 delay turn-on in units of 32 pwm clock periods.
// - overcurrent bits 8 and 0 pick lowest threshold level 1, 2 or 3.
// - no current sensing while an overcurrent window is active.
// - overcurrent bit 7 picks external divide by 512, else 256.
// - overcurrent bit 6 set selects the internal oscillator.
// - overcurrent bit 5 set selects low-current sense ratio.
// - low-current ratio lowers all thresholds by a factor three.
// - lighting uses three thresholds, motor uses high and low only.
// - bits 4:3 time windows: two in lighting, one of four in motor.
// - bit 2 picks upper threshold, clear is the higher value.
// - bit 1 picks middle threshold, ignored in motor profile.
// - all fields clear on reset or logic-supply failure.
// - global bits 8 and 7 start channel 1 and channel 0.
`timescale 1ns/10ps
module swc_channel_config #(
	parameter int NUM_CH = swc_pkg::NUM_CH
) (
	input  wire logic			CLK_SYS,
	input  wire logic			RESETN,
	input  wire logic			LOGIC_SUPPLY_FAIL,
	input  wire logic			SCLK,
	input  wire logic			CSB_N,
	input  wire logic			SI,
	output logic			SO,
	input  wire logic			EXT_CLK,
	input  wire logic [NUM_CH-1:0]	INT_OSC_TICK,
	input  wire logic [NUM_CH-1:0]	DIRECT_IN,
	input  wire logic [NUM_CH-1:0]	LOAD_TYPE_IN,
	input  wire logic [NUM_CH-1:0]	OC_WINDOW_ACTIVE,
	output logic [NUM_CH-1:0]		CH_ON,
	output swc_pkg::swc_ch_ctrl_type	CH0_CTRL,
	output swc_pkg::swc_ch_ctrl_type	CH1_CTRL
);
	localparam int W = swc_pkg::WORD_W;
	localparam int D = swc_pkg::DATA_W;

	logic				clear_all;
	logic				word_strobe;
	logic				word_reject;
	logic [W-1:0]			word_data;
	logic [W-1:0]			reply_word;
	logic				wr_bank;
	logic [2:0]			wr_addr;
	logic [D-1:0]			wr_value;

	logic [D-1:0]			pwm_ff [NUM_CH];
	logic [D-1:0]			nxt_pwm [NUM_CH];
	logic [D-1:0]			load_type_input_ff [NUM_CH];
	logic [D-1:0]			nxt_load_type_input [NUM_CH];
	logic [D-1:0]			oc_ff [NUM_CH];
	logic [D-1:0]			nxt_oc [NUM_CH];
	logic [D-1:0]			glb_ff, nxt_glb;
	logic [3:0]			sel_ff, nxt_sel;
	logic				wd_ff, nxt_wd;
	logic				pfault_ff, nxt_pfault;
	logic [D-1:0]			read_value;
	logic [NUM_CH-1:0]		pwm_on;
	swc_pkg::swc_ch_ctrl_type	ch_ctrl [NUM_CH];

	// supply failure wipes the bank like a reset does
	assign clear_all = ~RESETN | LOGIC_SUPPLY_FAIL;

	// serial port: words arrive whole or not at all
	swc_serial_port #(
		.WORD_W		(W)
	) u_port (
		.clk		(CLK_SYS),
		.rst_n		(RESETN),
		.sclk		(SCLK),
		.csb_n		(CSB_N),
		.mosi		(SI),
		.reply_word	(reply_word),
		.miso		(SO),
		.word_strobe	(word_strobe),
		.word_reject	(word_reject),
		.word_data	(word_data)
	);

	// address fields of the received word
	assign wr_bank = word_data[swc_pkg::BIT_BANK];
	assign wr_addr = word_data[swc_pkg::ADDR_HI:swc_pkg::ADDR_LO];
	assign wr_value = word_data[D-1:0];

	// register bank writes; only a validated word touches them
	always_comb
	begin
		nxt_glb = glb_ff;
		nxt_sel = sel_ff;
		nxt_wd = wd_ff;
		nxt_pfault = pfault_ff;
		for (int c = 0; c < NUM_CH; c++)
		begin
			nxt_pwm[c] = pwm_ff[c];
			nxt_load_type_input[c] = load_type_input_ff[c];
			nxt_oc[c] = oc_ff[c];
		end
		if (word_reject)
			nxt_pfault = 1'b1; // old selection is kept for readback
		if (word_strobe)
		begin
			nxt_wd = word_data[swc_pkg::BIT_WD];
			nxt_pfault = 1'b0;
			case (wr_addr)
				swc_pkg::ADDR_STATUS:
					nxt_sel = {wr_bank, word_data[swc_pkg::SEL_HI:0]};
				swc_pkg::ADDR_PWM:
					nxt_pwm[wr_bank] = wr_value;
				swc_pkg::ADDR_LOAD_TYPE_INPUT:
					nxt_load_type_input[wr_bank] = wr_value;
				swc_pkg::ADDR_OC:
					nxt_oc[wr_bank] = wr_value;
				swc_pkg::ADDR_GLOBAL:
				begin
					// global register exists in bank 0 only
					if (!wr_bank)
						nxt_glb = wr_value;
				end
				default:
					nxt_glb = glb_ff;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (clear_all)
		begin
			glb_ff <= swc_pkg::REG_RESET;
			sel_ff <= '0;
			wd_ff <= 1'b0;
			pfault_ff <= 1'b0;
			for (int c = 0; c < NUM_CH; c++)
			begin
				pwm_ff[c] <= swc_pkg::REG_RESET;
				load_type_input_ff[c] <= swc_pkg::REG_RESET;
				oc_ff[c] <= swc_pkg::REG_RESET;
			end
		end
		else
		begin
			glb_ff <= nxt_glb;
			sel_ff <= nxt_sel;
			wd_ff <= nxt_wd;
			pfault_ff <= nxt_pfault;
			for (int c = 0; c < NUM_CH; c++)
			begin
				pwm_ff[c] <= nxt_pwm[c];
				load_type_input_ff[c] <= nxt_load_type_input[c];
				oc_ff[c] <= nxt_oc[c];
			end
		end
	end

	// readback of the register picked by the last status word
	always_comb
	begin
		case (sel_ff[2:0])
			swc_pkg::ADDR_PWM:
				read_value = pwm_ff[sel_ff[3]];
			swc_pkg::ADDR_LOAD_TYPE_INPUT:
				read_value = load_type_input_ff[sel_ff[3]];
			swc_pkg::ADDR_OC:
				read_value = oc_ff[sel_ff[3]];
			swc_pkg::ADDR_GLOBAL:
				read_value = glb_ff;
			default:
				read_value = '0;
		endcase
	end

	// reply frame: watchdog echo, parity fault, selection, mode, data
	assign reply_word = {wd_ff, pfault_ff, sel_ff, swc_pkg::NORMAL_MODE, read_value};

	// per-channel pwm and control decode
	for (genvar i = 0; i < NUM_CH; i++)
	begin : g_ch
		logic [D-1:0]			p;
		logic [D-1:0]			c;
		logic [D-1:0]			o;
		logic				motor;
		swc_pkg::swc_ch_ctrl_type	ctrl_ff;
		swc_pkg::swc_ch_ctrl_type	nxt_ctrl;

		assign p = pwm_ff[i];
		assign c = load_type_input_ff[i];
		assign o = oc_ff[i];
		assign motor = LOAD_TYPE_IN[i];

		swc_pwm_engine #(
			.DUTY_W		(swc_pkg::DUTY_W)
		) u_pwm (
			.clk		(CLK_SYS),
			.rst_n		(~clear_all),
			.run		(glb_ff[swc_pkg::GLB_START0 + i]),
			.enable		(p[swc_pkg::PWM_ENABLE]),
			.duty		(p[swc_pkg::DUTY_W-1:0]),
			.delay		(c[swc_pkg::LOAD_TYPE_INPUT_DELAY_HI:0]),
			.use_internal	(o[swc_pkg::OC_INTCLK]),
			.long_prescale	(o[swc_pkg::OC_PRESCALE]),
			.int_tick	(INT_OSC_TICK[i]),
			.ext_clk	(EXT_CLK),
			.pwm_on		(pwm_on[i])
		);

		// decoded controls are registered so the analog side sees clean levels
		always_comb
		begin
			nxt_ctrl = '0;
			// direct input adds to pwm unless direct control is off
			nxt_ctrl.drive_on = pwm_on[i] |
				(DIRECT_IN[i] & ~c[swc_pkg::LOAD_TYPE_INPUT_DIRECT_OFF]);
			nxt_ctrl.short_detect_en = ~c[swc_pkg::LOAD_TYPE_INPUT_SHORT_OFF];
			nxt_ctrl.on_openload_en = ~c[swc_pkg::LOAD_TYPE_INPUT_ONOL_OFF];
			nxt_ctrl.off_openload_en = ~c[swc_pkg::LOAD_TYPE_INPUT_OFFOL_OFF];
			nxt_ctrl.slew_code = c[swc_pkg::LOAD_TYPE_INPUT_SLEW_HI:swc_pkg::LOAD_TYPE_INPUT_SLEW_LO];
			// range bit clear forces level 1 whatever the lower bit says
			if (!o[swc_pkg::OC_RANGE])
				nxt_ctrl.low_thr_level = swc_pkg::LOW_THR_L1;
			else if (o[swc_pkg::OC_LOWER])
				nxt_ctrl.low_thr_level = swc_pkg::LOW_THR_L3;
			else
				nxt_ctrl.low_thr_level = swc_pkg::LOW_THR_L2;
			nxt_ctrl.upper_thr_low = o[swc_pkg::OC_UPPER];
			nxt_ctrl.middle_thr_used = ~motor;
			nxt_ctrl.middle_thr_low = ~motor & o[swc_pkg::OC_MIDDLE];
			nxt_ctrl.sense_low_ratio = o[swc_pkg::OC_SENSE];
			nxt_ctrl.thr_div_three = o[swc_pkg::OC_SENSE];
			nxt_ctrl.sense_allowed = ~OC_WINDOW_ACTIVE[i];
			nxt_ctrl.motor_profile = motor;
			// lighting: bit 4 first window, bit 3 second; motor: 2-bit code
			nxt_ctrl.window_code = {o[swc_pkg::OC_WIN_FIRST],
				o[swc_pkg::OC_WIN_SECOND]};
		end

		always_ff @(posedge CLK_SYS)
		begin
			if (clear_all)
				ctrl_ff <= '0;
			else
				ctrl_ff <= nxt_ctrl;
		end

		assign ch_ctrl[i] = ctrl_ff;
		assign CH_ON[i] = ctrl_ff.drive_on;
	end

	assign CH0_CTRL = ch_ctrl[0];
	assign CH1_CTRL = ch_ctrl[1];
endmodule : swc_channel_config

// file: swc_spi_master.sv
// serial bus master model standing in for the host controller
`timescale 1ns/10ps
module swc_spi_master (
	input  wire logic	clk,
	input  wire logic	so,
	output logic		sclk,
	output logic		csb_n,
	output logic		si
);
	// clk cycles per sclk phase, above the one that the port needs
	localparam int PH = 3;

	// idle bus: clock parked low, frame deselected
	initial
	begin
		sclk = 1'b0;
		csb_n = 1'b1;
		si = 1'b0;
	end

	// wait n clk edges, then step just past the edge
	task automatic wc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wc

	// one frame of nb bits, msb first; bad_par breaks the odd parity on purpose
	task automatic xfer(input logic b, input logic [2:0] adr, input logic [8:0] dat,
		input logic bad_par, input int nb, output logic [15:0] rep);
		logic [15:0] w;
		w = {2'h0, b, adr, 1'h0, dat};
		w[14] = ~(^w) ^ bad_par;
		rep = 16'h0000;
		wc(1);
		csb_n = 1'b0;
		for (int i = 15; i > 15 - nb; i--)
		begin
			si = w[i];
			wc(PH);
			rep[i] = so;
			sclk = 1'b1;
			wc(PH);
			sclk = 1'b0;
		end
		wc(PH);
		csb_n = 1'b1;
		si = ~si; // released line must not keep showing the last bit
		wc(6);
	endtask : xfer
endmodule : swc_spi_master

// file: swc_channel_config_asserts.sv
// port-level assertions for the channel configuration block
`timescale 1ns/10ps
module swc_channel_config_asserts #(
	parameter int NUM_CH = swc_pkg::NUM_CH
) (
	input wire logic			CLK_SYS,
	input wire logic			RESETN,
	input wire logic			LOGIC_SUPPLY_FAIL,
	input wire logic [NUM_CH-1:0]	LOAD_TYPE_IN,
	input wire logic [NUM_CH-1:0]	OC_WINDOW_ACTIVE,
	input wire logic [NUM_CH-1:0]	CH_ON,
	input wire swc_pkg::swc_ch_ctrl_type	CH0_CTRL,
	input wire swc_pkg::swc_ch_ctrl_type	CH1_CTRL
);
	default clocking dc @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	// clearing: reset and supply loss leave CH_ON and both channel control words at zero
	a_reset_clear: assert property ($rose(RESETN) |-> {CH_ON, CH0_CTRL, CH1_CTRL} == '0)
		else $error("outputs not clear after reset");
	a_fail_clear: assert property (LOGIC_SUPPLY_FAIL |=> {CH_ON, CH0_CTRL, CH1_CTRL} == '0)
		else $error("outputs not clear after supply fail");
	// decoded controls follow their inputs one edge later
	a_sense_window: assert property (!LOGIC_SUPPLY_FAIL |=>
		{CH1_CTRL.sense_allowed, CH0_CTRL.sense_allowed} == ~$past(OC_WINDOW_ACTIVE))
		else $error("sense allowed during window");
	a_motor_follow: assert property (!LOGIC_SUPPLY_FAIL |=>
		{CH1_CTRL.motor_profile, CH0_CTRL.motor_profile} == $past(LOAD_TYPE_IN))
		else $error("profile not following load type");
	a_middle_used: assert property ($past(RESETN) && !$past(LOGIC_SUPPLY_FAIL) |->
		CH0_CTRL.middle_thr_used != CH0_CTRL.motor_profile)
		else $error("middle threshold use wrong");
	a_motor_no_mid: assert property (CH0_CTRL.motor_profile |-> !CH0_CTRL.middle_thr_low)
		else $error("middle select active in motor profile");
	a_div_three: assert property (CH0_CTRL.thr_div_three == CH0_CTRL.sense_low_ratio &&
		CH1_CTRL.thr_div_three == CH1_CTRL.sense_low_ratio)
		else $error("threshold scaling not tied to sense ratio");
	// level 0 is not a legal lowest threshold once decoding runs
	a_low_level: assert property ($past(RESETN) && !$past(LOGIC_SUPPLY_FAIL) |->
		CH0_CTRL.low_thr_level != 2'h0 && CH1_CTRL.low_thr_level != 2'h0)
		else $error("lowest threshold level out of range");
endmodule : swc_channel_config_asserts

bind swc_channel_config swc_channel_config_asserts #(.NUM_CH(NUM_CH)) swc_channel_config_asserts_i (
	.CLK_SYS(CLK_SYS),
	.RESETN(RESETN),
	.LOGIC_SUPPLY_FAIL(LOGIC_SUPPLY_FAIL),
	.LOAD_TYPE_IN(LOAD_TYPE_IN),
	.OC_WINDOW_ACTIVE(OC_WINDOW_ACTIVE),
	.CH_ON(CH_ON),
	.CH0_CTRL(CH0_CTRL),
	.CH1_CTRL(CH1_CTRL)
);

// file: tb_top.sv
// self-checking bench for the channel configuration block
`timescale 1ns/10ps
`define CHK(nm, exp, act) \
	begin \
		comparisons++; \
		if ((act) !== (exp)) \
		begin \
			bad_count++; \
			$display("BAD %s expected %h seen %h", nm, exp, act); \
		end \
	end
module tb_top;
	logic				CLK_SYS;
	logic				RESETN;
	logic				LOGIC_SUPPLY_FAIL;
	logic				SCLK;
	logic				CSB_N;
	logic				SI;
	logic				SO;
	logic [1:0]			cnt;
	logic [1:0]			DIRECT_IN;
	logic [1:0]			LOAD_TYPE_IN;
	logic [1:0]			OC_WINDOW_ACTIVE;
	logic [1:0]			CH_ON;
	swc_pkg::swc_ch_ctrl_type	CH0_CTRL;
	swc_pkg::swc_ch_ctrl_type	CH1_CTRL;
	logic [15:0]			rep;
	int				bad_count = 0;
	int				comparisons = 0;
	int				cycles = 0;
	logic [2:0]	adrs [3] = '{swc_pkg::ADDR_PWM, swc_pkg::ADDR_LOAD_TYPE_INPUT, swc_pkg::ADDR_OC};
	logic [8:0]	ocv [3] = '{9'h040, 9'h000, 9'h080};
	int		stp [3] = '{4, 2, 4};
	logic [7:0]	dut [3] = '{8'h01, 8'h80, 8'hff};

	swc_channel_config swc_channel_config_i (
		.CLK_SYS(CLK_SYS), .RESETN(RESETN), .LOGIC_SUPPLY_FAIL(LOGIC_SUPPLY_FAIL),
		.SCLK(SCLK), .CSB_N(CSB_N), .SI(SI), .SO(SO), .EXT_CLK(cnt[0]),
		.INT_OSC_TICK({2{cnt == 2'h3}}), .DIRECT_IN(DIRECT_IN), .LOAD_TYPE_IN(LOAD_TYPE_IN),
		.OC_WINDOW_ACTIVE(OC_WINDOW_ACTIVE), .CH_ON(CH_ON), .CH0_CTRL(CH0_CTRL),
		.CH1_CTRL(CH1_CTRL)
	);
	swc_spi_master swc_spi_master_i (
		.clk(CLK_SYS), .so(SO), .sclk(SCLK), .csb_n(CSB_N), .si(SI)
	);

	// 40 ns system clock
	initial
	begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end
	// pwm step sources: external rises every 2 cycles, internal tick every 4
	always @(posedge CLK_SYS)
		#1 cnt <= cnt + 2'h1;
	// hang guard, well above the roughly 20000 cycles the run needs
	always @(posedge CLK_SYS)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			bad_count++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	task automatic wr(input logic b, input logic [2:0] a, input logic [8:0] d);
		swc_spi_master_i.xfer(b, a, d, 1'b0, 16, rep);
	endtask : wr

	// the reply to a status word comes in the frame after it
	task automatic rdchk(input logic b, input logic [2:0] s, input logic [8:0] e);
		repeat (2)
			swc_spi_master_i.xfer(b, swc_pkg::ADDR_STATUS, {6'h00, s}, 1'b0, 16, rep);
		`CHK("reply", {2'h0, b, s, 1'b1, e}, rep)
	endtask : rdchk

	// skip one rise (a duty change may cause a stray one), then time one period
	task automatic meas(input int ch, input int st, input logic [7:0] d);
		logic	pv;
		int	t;
		int	h;
		t = 0;
		h = 0;
		repeat (2)
		begin
			pv = 1'b1;
			while (!(pv === 1'b0 && CH_ON[ch] === 1'b1) && t < 5000)
			begin
				pv = CH_ON[ch];
				swc_spi_master_i.wc(1);
				t++;
			end
		end
		for (int i = 0; i < 256 * st; i++)
		begin
			h += (CH_ON[ch] === 1'b1);
			pv = CH_ON[ch];
			swc_spi_master_i.wc(1);
		end
		`CHK("on cycles", int'(d) * st, h)
		`CHK("period end", 2'h1, {pv, CH_ON[ch]})
	endtask : meas

	// cycles from a channel 0 period start to the delayed channel 1 switch-on
	task automatic lag;
		logic	pv;
		int	t;
		pv = 1'b1;
		t = 0;
		while (!(pv === 1'b0 && CH_ON[0] === 1'b1) && t < 3000)
		begin
			pv = CH_ON[0];
			swc_spi_master_i.wc(1);
			t++;
		end
		t = 0;
		while (CH_ON[1] !== 1'b1 && t < 1000)
		begin
			swc_spi_master_i.wc(1);
			t++;
		end
		// one delay unit of steps, internal tick every 4 cycles
		`CHK("turn-on lag", 4 << swc_pkg::DELAY_UNIT_LOG2, t)
	endtask : lag

	// main sequence
	initial
	begin
		RESETN = 1'b0;
		LOGIC_SUPPLY_FAIL = 1'b0;
		DIRECT_IN = 2'h0;
		LOAD_TYPE_IN = 2'h0;
		OC_WINDOW_ACTIVE = 2'h0;
		cnt = 2'h0;
		repeat (16) @(posedge CLK_SYS);
		#1 RESETN = 1'b1;
		swc_spi_master_i.wc(2);
		`CHK("ctrl0 defaults", 10'h38a, CH0_CTRL[15:6])
		for (int i = 0; i < 6; i++)
			rdchk(i[0], adrs[i / 2], 9'h000);
		for (int i = 0; i < 6; i++)
			wr(i[0], adrs[i / 2], 9'h1a5 ^ 9'(i));
		for (int i = 0; i < 6; i++)
			rdchk(i[0], adrs[i / 2], 9'h1a5 ^ 9'(i));
		// bank routing and detection disables
		wr(1'b0, swc_pkg::ADDR_LOAD_TYPE_INPUT, 9'h1c0);
		wr(1'b1, swc_pkg::ADDR_LOAD_TYPE_INPUT, 9'h080);
		`CHK("ch0 detect", 3'h0, CH0_CTRL[15:13])
		`CHK("ch1 detect", 3'h5, CH1_CTRL[15:13])
		for (int s = 0; s < 4; s++)
		begin
			wr(1'b1, swc_pkg::ADDR_LOAD_TYPE_INPUT, {4'h0, 2'(s), 3'h0});
			`CHK("slew", 2'(s), CH1_CTRL.slew_code)
		end
		// lowest threshold from bits 8 and 0
		for (int c = 0; c < 4; c++)
		begin
			wr(1'b0, swc_pkg::ADDR_OC, {c[1], 7'h00, c[0]});
			`CHK("low level", c[1] ? {1'b1, c[0]} : 2'h1, CH0_CTRL.low_thr_level)
		end
		wr(1'b0, swc_pkg::ADDR_OC, 9'h03e);
		`CHK("lighting", 9'h1fb, CH0_CTRL[8:0])
		LOAD_TYPE_IN = 2'h3;
		swc_spi_master_i.wc(2);
		`CHK("motor", 9'h13f, CH0_CTRL[8:0])
		`CHK("motor ch1", 1'b1, CH1_CTRL.motor_profile)
		LOAD_TYPE_IN = 2'h0;
		OC_WINDOW_ACTIVE = 2'h2;
		swc_spi_master_i.wc(2);
		`CHK("sense in window", 2'h1, {CH1_CTRL.sense_allowed, CH0_CTRL.sense_allowed})
		OC_WINDOW_ACTIVE = 2'h0;
		// refused frames leave the register alone and raise the parity flag
		wr(1'b0, swc_pkg::ADDR_PWM, 9'h0aa);
		swc_spi_master_i.xfer(1'b0, swc_pkg::ADDR_PWM, 9'h155, 1'b1, 16, rep);
		swc_spi_master_i.xfer(1'b0, swc_pkg::ADDR_PWM, 9'h155, 1'b0, 15, rep);
		swc_spi_master_i.xfer(1'b0, swc_pkg::ADDR_STATUS, 9'h000, 1'b0, 16, rep);
		`CHK("parity flag", 1'b1, rep[14])
		rdchk(1'b0, swc_pkg::ADDR_PWM, 9'h0aa);
		LOGIC_SUPPLY_FAIL = 1'b1;
		swc_spi_master_i.wc(2);
		LOGIC_SUPPLY_FAIL = 1'b0;
		rdchk(1'b0, swc_pkg::ADDR_PWM, 9'h000);
		// pwm under internal, external /256 and external /512 clocks
		wr(1'b0, swc_pkg::ADDR_LOAD_TYPE_INPUT, 9'h020);
		wr(1'b1, swc_pkg::ADDR_LOAD_TYPE_INPUT, 9'h020);
		wr(1'b0, swc_pkg::ADDR_GLOBAL, 9'h180);
		for (int k = 0; k < 3; k++)
		begin
			wr(1'b0, swc_pkg::ADDR_OC, ocv[k]);
			wr(1'b0, swc_pkg::ADDR_PWM, {1'b1, dut[k]});
			meas(0, stp[k], dut[k]);
		end
		`CHK("ch1 disabled", 1'b0, CH_ON[1])
		wr(1'b1, swc_pkg::ADDR_OC, 9'h040);
		wr(1'b1, swc_pkg::ADDR_PWM, 9'h140);
		meas(1, 4, 8'h40);
		// same clock and duty on both, restarted together; channel 1 one unit late
		wr(1'b0, swc_pkg::ADDR_OC, 9'h040);
		wr(1'b0, swc_pkg::ADDR_PWM, 9'h140);
		wr(1'b1, swc_pkg::ADDR_LOAD_TYPE_INPUT, 9'h021);
		wr(1'b0, swc_pkg::ADDR_GLOBAL, 9'h000);
		`CHK("stopped", 2'h0, CH_ON)
		wr(1'b0, swc_pkg::ADDR_GLOBAL, 9'h180);
		lag();
		// direct input only counts while direct control is enabled
		wr(1'b0, swc_pkg::ADDR_PWM, 9'h000);
		wr(1'b1, swc_pkg::ADDR_PWM, 9'h000);
		DIRECT_IN = 2'h3;
		swc_spi_master_i.wc(4);
		`CHK("direct blocked", 2'h0, CH_ON)
		wr(1'b0, swc_pkg::ADDR_LOAD_TYPE_INPUT, 9'h000);
		`CHK("direct drive", 2'h1, CH_ON)
		end_of_test();
	end
endmodule : tb_top
